// ==== nvap_pkg.sv ====
// Package with register locations, field positions and timing for the port.
package nvap_pkg;
    // Special-function register locations.
    localparam logic [7:0] ADDR_NV_ADDRESS  = 8'h46;
    localparam logic [7:0] ADDR_NV_DATA     = 8'h47;
    localparam logic [7:0] ADDR_NV_CONTROL  = 8'h40;
    localparam logic [7:0] BANK_CONTROL     = 8'h01;
    localparam int         NV_DEPTH         = 128;
    localparam int         NV_AW            = 7;
    // Control field positions.
    localparam int         BIT_FETCH        = 0;
    localparam int         BIT_FETCH_PERMIT = 1;
    localparam int         BIT_PROGRAM      = 2;
    localparam int         BIT_PROG_PERMIT  = 3;
    localparam logic [7:0] RESET_BYTE       = 8'h00;
    localparam logic [3:0] CTRL_RESET       = 4'h0;
    // Write cycle time in microseconds and its count at 10 MHz.
    localparam int         CLK_MHZ          = 10;
    localparam int         PROG_TIME_US     = 4;
    localparam int         PROG_CYCLES      = PROG_TIME_US * CLK_MHZ;
    localparam logic [9:0] PROG_LAST        = 10'(PROG_CYCLES - 1);
    localparam logic [9:0] CNT_ZERO         = 10'h000;
    localparam logic [9:0] CNT_ONE          = 10'h001;
endpackage

// ==== nvap_port.sv ====
// Byte access port to a 128-byte nonvolatile store.
//
// Operation
// - Store holds 128 bytes, addresses 0 to 7F.
// - Store reachable only through port registers.
// - Each transfer moves exactly one byte.
// - Address and data registers directly addressed, bank 0.
// - Control register bank 1 location 40, indirect.
// - Address holds seven bits in low positions.
// - Address bit 7 always reads zero.
// - Program trigger needs permit; cleared when done.
// - Fetch trigger needs permit, else no effect.
// - Fetch end clears trigger, data register loaded.
// - Write end sets done flag; software clears.
`timescale 1ns/1ps
module nvap_port (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic       sfr_indirect,
    input  wire logic [7:0] sfr_bank,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       done_clear,
    output logic      [7:0] sfr_rdata,
    output logic            nv_done_flag,
    output logic            nv_busy
);
    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        NVAP_IDLE  = 3'b001,
        NVAP_FETCH = 3'b010,
        NVAP_PROG  = 3'b100
    } nvap_state_e;

    nvap_state_e state;
    logic [7:0]  nv_address_reg;
    logic [7:0]  nv_data_reg;
    logic [3:0]  nv_control_reg;
    logic [9:0]  prog_cnt;
    logic [7:0]  store [nvap_pkg::NV_DEPTH];
    logic        sel_addr;
    logic        sel_data;
    logic        sel_ctrl;
    logic [6:0]  nv_byte_index;

    assign sel_addr = !sfr_indirect && sfr_bank == nvap_pkg::RESET_BYTE
                      && sfr_addr == nvap_pkg::ADDR_NV_ADDRESS;
    assign sel_data = !sfr_indirect && sfr_bank == nvap_pkg::RESET_BYTE
                      && sfr_addr == nvap_pkg::ADDR_NV_DATA;
    assign sel_ctrl = sfr_indirect && sfr_bank == nvap_pkg::BANK_CONTROL
                      && sfr_addr == nvap_pkg::ADDR_NV_CONTROL;
    assign nv_byte_index = nv_address_reg[nvap_pkg::NV_AW-1:0];

    // ------------------------------------------------------------
    // Address register
    // ------------------------------------------------------------
    // Seven bits kept, cleared at reset.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            nv_address_reg <= nvap_pkg::RESET_BYTE;
        end else if (sfr_wr && sel_addr) begin
            nv_address_reg <= {1'b0, sfr_wdata[6:0]};
        end
    end

    // ------------------------------------------------------------
    // Control and sequencing
    // ------------------------------------------------------------
    // A write is committed only when the timer expires, so a reset
    // mid-cycle leaves the old byte intact.
    // Triggers gated by permits.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            nv_control_reg <= nvap_pkg::CTRL_RESET;
            state          <= NVAP_IDLE;
            prog_cnt       <= nvap_pkg::CNT_ZERO;
        end else begin
            case (state)
                NVAP_IDLE: begin
                    if (sfr_wr && sel_ctrl) begin
                        nv_control_reg <= sfr_wdata[3:0];
                        if (sfr_wdata[nvap_pkg::BIT_PROGRAM]
                            && nv_control_reg[nvap_pkg::BIT_PROG_PERMIT])
                        begin
                            state    <= NVAP_PROG;
                            prog_cnt <= nvap_pkg::CNT_ZERO;
                        end else if (sfr_wdata[nvap_pkg::BIT_FETCH]
                            && nv_control_reg[nvap_pkg::BIT_FETCH_PERMIT])
                        begin
                            state <= NVAP_FETCH;
                        end else begin
                            nv_control_reg[nvap_pkg::BIT_PROGRAM] <= 1'b0;
                            nv_control_reg[nvap_pkg::BIT_FETCH]   <= 1'b0;
                        end
                    end
                end
                NVAP_FETCH: begin
                    // Trigger cleared as the byte lands.
                    nv_control_reg[nvap_pkg::BIT_FETCH] <= 1'b0;
                    state <= NVAP_IDLE;
                end
                NVAP_PROG: begin
                    prog_cnt <= prog_cnt + nvap_pkg::CNT_ONE;
                    if (prog_cnt == nvap_pkg::PROG_LAST) begin
                        nv_control_reg[nvap_pkg::BIT_PROGRAM] <= 1'b0;
                        state <= NVAP_IDLE;
                    end
                end
                default: begin
                    state <= NVAP_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Store and data register
    // ------------------------------------------------------------
    // One byte moves per completed cycle.
    always_ff @(posedge clk_sys) begin
        if (state == NVAP_PROG && prog_cnt == nvap_pkg::PROG_LAST) begin
            store[nv_byte_index] <= nv_data_reg;
        end
    end

    // Fetched byte held until the next fetch or a write to the data register outside a program cycle.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            nv_data_reg <= nvap_pkg::RESET_BYTE;
        end else if (state == NVAP_FETCH) begin
            nv_data_reg <= store[nv_byte_index];
        end else if (sfr_wr && sel_data && state != NVAP_PROG) begin
            nv_data_reg <= sfr_wdata;
        end
    end

    // Done flag set wins over clear.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            nv_done_flag <= 1'b0;
        end else if (state == NVAP_PROG
                     && prog_cnt == nvap_pkg::PROG_LAST) begin
            nv_done_flag <= 1'b1;
        end else if (done_clear) begin
            nv_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            nv_busy <= 1'b0;
        end else begin
            nv_busy <= state != NVAP_IDLE;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Only the three registers answer reads.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sfr_rdata <= nvap_pkg::RESET_BYTE;
        end else if (sfr_rd && sel_addr) begin
            sfr_rdata <= {1'b0, nv_address_reg[6:0]};
        end else if (sfr_rd && sel_data) begin
            sfr_rdata <= nv_data_reg;
        end else if (sfr_rd && sel_ctrl) begin
            sfr_rdata <= {4'h0, nv_control_reg};
        end else begin
            sfr_rdata <= nvap_pkg::RESET_BYTE;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_addr_msb_zero: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        nv_address_reg[7] == 1'b0)
        else $error("address msb set");
    chk_prog_needs_permit: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (state == NVAP_IDLE && sfr_wr && sel_ctrl
        && !nv_control_reg[nvap_pkg::BIT_PROG_PERMIT]) |=> state != NVAP_PROG)
        else $error("write started without permit");
    chk_fetch_needs_permit: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (state == NVAP_IDLE && sfr_wr && sel_ctrl
        && !nv_control_reg[nvap_pkg::BIT_FETCH_PERMIT]
        && !sfr_wdata[nvap_pkg::BIT_PROGRAM]) |=> state == NVAP_IDLE)
        else $error("read started without permit");
    chk_fetch_clears: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        state == NVAP_FETCH |=> !nv_control_reg[nvap_pkg::BIT_FETCH]
        && nv_data_reg == store[$past(nv_byte_index)])
        else $error("fetch end wrong");
    chk_prog_done_flag: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        $rose(state == NVAP_PROG) |-> ##[40:41] nv_done_flag)
        else $error("done flag late");
    // The flag is sticky: only a software clear may drop it.
    chk_done_sticky: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (nv_done_flag && !done_clear) |=> nv_done_flag)
        else $error("done flag dropped");
    chk_done_set_wins: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (state == NVAP_PROG && prog_cnt == nvap_pkg::PROG_LAST)
        |=> nv_done_flag)
        else $error("done flag lost to clear");
    chk_direct_ctrl: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (sfr_wr && !sfr_indirect && state == NVAP_IDLE)
        |=> $stable(nv_control_reg))
        else $error("direct hit control");
    chk_data_read: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (sfr_rd && sel_data) |=> sfr_rdata == $past(nv_data_reg))
        else $error("data read wrong");
    chk_ctrl_read: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (sfr_rd && sel_ctrl) |=> sfr_rdata == {4'h0, $past(nv_control_reg)})
        else $error("control read wrong");
endmodule

// ==== test_nvap_port.sv ====
// Self-checking testbench for the nonvolatile byte access port.
`timescale 1ns/1ps
module test_nvap_port;
    // --------------------------------------------------------------
    // Stimulus signals and design instance
    // --------------------------------------------------------------
    logic       clk_sys      = 1'b0;
    logic       arst_n       = 1'b0;
    logic       sfr_wr       = 1'b0;
    logic       sfr_rd       = 1'b0;
    logic       sfr_indirect = 1'b0;
    logic [7:0] sfr_bank     = 8'h00;
    logic [7:0] sfr_addr     = 8'h00;
    logic [7:0] sfr_wdata    = 8'h00;
    logic       done_clear   = 1'b0;
    logic [7:0] sfr_rdata;
    logic       nv_done_flag;
    logic       nv_busy;
    logic [7:0] got;
    logic [7:0] na[2]        = '{8'h00, 8'h7F};
    logic [7:0] nd[2]        = '{8'hC3, 8'h3C};
    int         bad_count    = 0;
    int         check_count  = 0;

    always #50 clk_sys = ~clk_sys;

    nvap_port dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_indirect(sfr_indirect), .sfr_bank(sfr_bank),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .done_clear(done_clear),
        .sfr_rdata(sfr_rdata), .nv_done_flag(nv_done_flag),
        .nv_busy(nv_busy));

    // --------------------------------------------------------------
    // Access tasks
    // --------------------------------------------------------------
    // One strobe cycle; read data is registered, so it is taken a cycle on.
    task automatic access(input logic wr, input logic ind,
                          input logic [7:0] bank, input logic [7:0] addr,
                          input logic [7:0] wdata);
        @(negedge clk_sys);
        sfr_wr = wr;
        sfr_rd = ~wr;
        sfr_indirect = ind;
        sfr_bank = bank;
        sfr_addr = addr;
        sfr_wdata = wdata;
        @(negedge clk_sys);
        got = sfr_rdata;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
    endtask

    task automatic cmp(input logic [7:0] act, input logic [7:0] exp);
        check_count++;
        if (act !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic rreg(input logic ind, input logic [7:0] bank,
                        input logic [7:0] addr, input logic [7:0] exp);
        access(1'b0, ind, bank, addr, 8'h00);
        cmp(got, exp);
    endtask

    task automatic wctl(input logic [7:0] d);
        access(1'b1, 1'b1, nvap_pkg::BANK_CONTROL,
               nvap_pkg::ADDR_NV_CONTROL, d);
    endtask

    // Polls the control register until the given trigger bit falls.
    task automatic wait_clear(input int pos);
        int tries;
        tries = 0;
        got = 8'hFF;
        while (got[pos] !== 1'b0 && tries < 100) begin
            access(1'b0, 1'b1, nvap_pkg::BANK_CONTROL,
                   nvap_pkg::ADDR_NV_CONTROL, 8'h00);
            tries++;
        end
        cmp({7'h00, got[pos]}, 8'h00);
    endtask

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // --------------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        rreg(1'b0, 8'h00, nvap_pkg::ADDR_NV_ADDRESS, 8'h00);
        rreg(1'b1, 8'h01, 8'h40, 8'h00);
        access(1'b1, 1'b0, 8'h00, nvap_pkg::ADDR_NV_ADDRESS, 8'hFF);
        rreg(1'b0, 8'h00, nvap_pkg::ADDR_NV_ADDRESS, 8'h7F);
        access(1'b1, 1'b0, 8'h00, nvap_pkg::ADDR_NV_DATA, 8'hA5);
        rreg(1'b0, 8'h00, nvap_pkg::ADDR_NV_DATA, 8'hA5);
        access(1'b1, 1'b0, 8'h01, 8'h40, 8'h0F);
        rreg(1'b0, 8'h01, 8'h40, 8'h00);
        rreg(1'b1, 8'h01, 8'h40, 8'h00);
        wctl(8'h04);
        rreg(1'b1, 8'h01, 8'h40, 8'h00);
        cmp({7'h00, nv_busy}, 8'h00);
        wctl(8'h01);
        rreg(1'b1, 8'h01, 8'h40, 8'h00);
        // The two ends of the address range, 00 and 7F, drive all seven index bits low and then high.
        for (int i = 0; i < 2; i++) begin
            access(1'b1, 1'b0, 8'h00, nvap_pkg::ADDR_NV_ADDRESS, na[i]);
            access(1'b1, 1'b0, 8'h00, nvap_pkg::ADDR_NV_DATA, nd[i]);
            wctl(8'h08);
            wctl(8'h0C);
            @(negedge clk_sys);
            cmp({7'h00, nv_busy}, 8'h01);
            cmp({7'h00, nv_done_flag}, 8'h00);
            wait_clear(nvap_pkg::BIT_PROGRAM);
            cmp({7'h00, nv_done_flag}, 8'h01);
            rreg(1'b1, 8'h01, 8'h40, 8'h08);
            @(negedge clk_sys);
            done_clear = 1'b1;
            @(negedge clk_sys);
            done_clear = 1'b0;
            cmp({7'h00, nv_done_flag}, 8'h00);
        end
        wctl(8'h02);
        for (int i = 0; i < 2; i++) begin
            access(1'b1, 1'b0, 8'h00, nvap_pkg::ADDR_NV_ADDRESS, na[i]);
            access(1'b1, 1'b0, 8'h00, nvap_pkg::ADDR_NV_DATA, 8'h00);
            wctl(8'h03);
            wait_clear(nvap_pkg::BIT_FETCH);
            rreg(1'b0, 8'h00, nvap_pkg::ADDR_NV_DATA, nd[i]);
            rreg(1'b1, 8'h01, 8'h40, 8'h02);
        end
        conclude();
    end

    // Guards against a sequence that never concludes; wait_clear stops polling a stuck trigger bit after 100 tries.
    initial begin
        repeat (30000) @(posedge clk_sys);
        bad_count++;
        $display("ERROR at %0t: watchdog expired", $time);
        conclude();
    end
endmodule
